// file: include/msh_pkg.sv
// Operation
// - Fresh execute request starts a transmission
// - Abort request forcibly ends the transmission
// - Abort wins over a simultaneous execute
// - Device type codes 6 and 16
// - Protocol 1 is the request/response protocol
// - Protocol 2 sends words, expects no reply
// - Protocol 3 sends bytes, expects no reply
// - Circuit number valid from 1 to 8
// - Channel 1-10 first variant, 1-4 second
// - Second variant shares four channels both ways
// - Parameter list is 17 words from pointer
// - Requester fills list, block writes result back; the code writes none after an abort or a refused request
// - Busy held during transmission or abort
// - Completion flag pulses exactly one scan
// - Error flag pulses exactly one scan
// - Result byte 00 busy, 10 done, 8x error
package msh_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] MSH_ADDR_CTRL = 12'h000;
    localparam logic [11:0] MSH_ADDR_SEL = 12'h004;
    localparam logic [11:0] MSH_ADDR_PTR = 12'h008;
    localparam logic [11:0] MSH_ADDR_STAT = 12'h00c;
    localparam logic [11:0] MSH_ADDR_LIST = 12'h100;
    localparam logic [11:0] MSH_ADDR_LIST_END = 12'h1fc;

    // Control bits
    localparam int MSH_CTRL_EXEC = 0;
    localparam int MSH_CTRL_ABORT = 1;

    // Status bits
    localparam int MSH_STAT_BUSY = 0;
    localparam int MSH_STAT_OK = 1;
    localparam int MSH_STAT_ERR = 2;
    localparam int MSH_STAT_RES_LO = 8;

    // ------------------------------------------------------------
    // Selector codes
    // ------------------------------------------------------------
    localparam logic [7:0] MSH_DEV_VAR1 = 8'h06;
    localparam logic [7:0] MSH_DEV_VAR2 = 8'h10;
    localparam logic [7:0] MSH_PROTO_REQRSP = 8'h01;
    localparam logic [7:0] MSH_PROTO_RAW_WORD = 8'h02;
    localparam logic [7:0] MSH_PROTO_RAW_BYTE = 8'h03;
    localparam logic [7:0] MSH_CIRC_MIN = 8'h01;
    localparam logic [7:0] MSH_CIRC_MAX = 8'h08;
    localparam logic [7:0] MSH_CHAN_MIN = 8'h01;
    localparam logic [7:0] MSH_CHAN_MAX_VAR1 = 8'h0a;
    localparam logic [7:0] MSH_CHAN_MAX_VAR2 = 8'h04;

    // ------------------------------------------------------------
    // Parameter list layout and result codes
    // ------------------------------------------------------------
    localparam int MSH_LIST_WORDS = 17;
    localparam logic [7:0] MSH_RES_BUSY = 8'h00;
    localparam logic [7:0] MSH_RES_DONE = 8'h10;
    localparam logic [3:0] MSH_RES_ERR_HI = 4'h8;
    localparam logic [3:0] MSH_ERR_SELECT = 4'hf;
    localparam logic [3:0] MSH_ERR_NONE = 4'h0;

    // Ladder handshake state
    typedef enum logic [1:0] {
        MSH_ST_IDLE,
        MSH_ST_SEND,
        MSH_ST_ABORT
    } msh_state_e;

    // Request to the transfer engine
    typedef struct packed {
        logic start;
        logic abort;
        logic expect_reply;
        logic byte_mode;
        logic [7:0] dev_type;
        logic [7:0] protocol;
        logic [7:0] circuit;
        logic [7:0] channel;
        logic [7:0] list_ptr;
    } msh_xfer_req_s;

    // Answer from the transfer engine
    typedef struct packed {
        logic done;
        logic fail;
        logic [3:0] code;
        logic [7:0] detail;
    } msh_xfer_rsp_s;

    // Handshake flags toward the requester
    typedef struct packed {
        logic busy;
        logic complete;
        logic error;
    } msh_flags_s;

endpackage

// file: logic/msh_param_ram.sv
`timescale 1ns/10ps
module msh_param_ram #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // Clock
    input wire logic hclk,
    // Bus port
    input wire logic bus_we,
    input wire logic [AW-1:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    // Handshake engine write port, wins over the bus
    input wire logic fsm_we,
    input wire logic [AW-1:0] fsm_addr,
    input wire logic [15:0] fsm_wdata,
    // Transfer engine read port
    input wire logic [AW-1:0] eng_addr,
    output logic [15:0] eng_rdata
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] mem [DEPTH];

    // Writes: result words must never be lost to a bus write
    always_ff @(posedge hclk) begin
        if (fsm_we) begin
            mem[fsm_addr] <= fsm_wdata;
        end
        if (bus_we && !(fsm_we && fsm_addr == bus_addr)) begin
            mem[bus_addr] <= bus_wdata;
        end
    end

    // Registered reads on both read ports
    always_ff @(posedge hclk) begin
        bus_rdata <= mem[bus_addr];
        eng_rdata <= mem[eng_addr];
    end
endmodule

// file: logic/msh_ahb_slave.sv
`timescale 1ns/10ps
module msh_ahb_slave (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave side
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    // Register access toward the core
    output logic wr_en,
    output logic [11:0] acc_addr,
    output logic rd_cap
);
    // ------------------------------------------------------------
    // Data-phase tracking
    // ------------------------------------------------------------
    // Reads take two wait states: the list memory reads a cycle after
    // its address, and read data is captured a cycle after that.
    typedef struct packed {
        logic wr_pend;
        logic rd_pend;
        logic rd_wait;
        logic [11:0] addr;
    } msh_ahb_s;

    msh_ahb_s q;
    msh_ahb_s next_q;
    logic take;

    assign take = hsel && hready && htrans[1];
    assign hreadyout = !(q.rd_pend || q.rd_wait);
    assign hresp = 1'b0;
    assign wr_en = q.wr_pend;
    assign rd_cap = q.rd_wait;
    assign acc_addr = q.addr;

    // Next state of the address/data phase tracker
    always_comb begin
        next_q = q;
        next_q.wr_pend = 1'b0;
        next_q.rd_wait = 1'b0;
        if (q.rd_pend) begin
            // First data-phase cycle of a read: stall once
            next_q.rd_pend = 1'b0;
            next_q.rd_wait = 1'b1;
        end else if (take) begin
            next_q.addr = {haddr[11:2], 2'b00};
            next_q.wr_pend = hwrite;
            next_q.rd_pend = !hwrite;
        end
    end

    // Tracker registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
endmodule

// file: logic/msh_top.sv
`timescale 1ns/10ps
module msh_top #(
    parameter int LIST_DEPTH = 64,
    parameter int LIST_AW = 6
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Transfer engine
    output msh_pkg::msh_xfer_req_s xfer_req,
    input wire msh_pkg::msh_xfer_rsp_s xfer_rsp,
    input wire logic [LIST_AW-1:0] eng_addr,
    output logic [15:0] eng_rdata,
    // Handshake flags
    output msh_pkg::msh_flags_s flags
);
    import msh_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        msh_state_e st;         // Handshake state
        logic exec;             // Execute request bit from software
        logic abort;            // Abort request bit from software
        logic exec_q;           // Last scan's execute, for edge
        logic abort_q;          // Last scan's abort, for edge
        logic [31:0] sel;       // Selector register
        logic [LIST_AW-1:0] ptr; // Parameter list start
        logic busy;
        logic complete;
        logic error;
        logic last_ok;          // Last request ended well
        logic last_err;         // Last request ended in error
        logic [7:0] result;     // Last result byte
        logic start;            // One-cycle start to engine
        logic abort_req;        // One-cycle abort to engine
        logic stat_pend;        // Status word still to write
        logic [15:0] stat_word;
        logic [31:0] rdata;
    } msh_top_s;

    msh_top_s q;
    msh_top_s next_q;

    // Bus slave side
    logic wr_en;
    logic [11:0] acc_addr;
    logic rd_cap;
    logic list_hit;
    logic [15:0] list_rdata;
    logic list_bus_we;

    // Handshake engine write port into the list
    logic fsm_we;
    logic [LIST_AW-1:0] fsm_addr;
    logic [15:0] fsm_wdata;

    // Decoded selectors
    logic [7:0] dev_type;
    logic [7:0] protocol;
    logic [7:0] circuit;
    logic [7:0] channel;
    logic dev_ok;
    logic proto_ok;
    logic circ_ok;
    logic chan_ok;
    logic sel_ok;
    logic ptr_ok;
    logic exec_rise;
    logic abort_rise;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    msh_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr[11:0]),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .wr_en(wr_en),
        .acc_addr(acc_addr),
        .rd_cap(rd_cap)
    );

    // List window sits on whole words from the list base
    assign list_hit = (acc_addr >= MSH_ADDR_LIST) &&
                      (acc_addr <= MSH_ADDR_LIST_END);
    assign list_bus_we = wr_en && list_hit;

    msh_param_ram #(
        .DEPTH(LIST_DEPTH),
        .AW(LIST_AW)
    ) u_list (
        .hclk(hclk),
        .bus_we(list_bus_we),
        .bus_addr(acc_addr[LIST_AW+1:2]),
        .bus_wdata(hwdata[15:0]),
        .bus_rdata(list_rdata),
        .fsm_we(fsm_we),
        .fsm_addr(fsm_addr),
        .fsm_wdata(fsm_wdata),
        .eng_addr(eng_addr),
        .eng_rdata(eng_rdata)
    );

    // ------------------------------------------------------------
    // Selector checks
    // ------------------------------------------------------------
    assign dev_type = q.sel[7:0];
    assign protocol = q.sel[15:8];
    assign circuit = q.sel[23:16];
    assign channel = q.sel[31:24];
    // Only the two known device variants are accepted
    assign dev_ok = (dev_type == MSH_DEV_VAR1) ||
                    (dev_type == MSH_DEV_VAR2);
    // Only the three known protocol codes are accepted
    assign proto_ok = (protocol == MSH_PROTO_REQRSP) ||
                      (protocol == MSH_PROTO_RAW_WORD) ||
                      (protocol == MSH_PROTO_RAW_BYTE);
    assign circ_ok = (circuit >= MSH_CIRC_MIN) &&
                     (circuit <= MSH_CIRC_MAX);
    // Variant two has four shared channels
    assign chan_ok = (channel >= MSH_CHAN_MIN) &&
                     (channel <= ((dev_type == MSH_DEV_VAR2) ?
                                  MSH_CHAN_MAX_VAR2 :
                                  MSH_CHAN_MAX_VAR1));
    assign sel_ok = dev_ok && proto_ok && circ_ok && chan_ok;
    // Whole 17-word list must fit in the window
    assign ptr_ok = ({1'b0, q.ptr} + (LIST_AW+1)'(MSH_LIST_WORDS))
                    <= (LIST_AW+1)'(LIST_DEPTH);

    // Edges taken once per scan; a held bit never restarts
    assign exec_rise = q.exec && !q.exec_q;
    assign abort_rise = q.abort && !q.abort_q;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.exec_q = q.exec;
        next_q.abort_q = q.abort;
        next_q.complete = 1'b0;
        next_q.error = 1'b0;
        next_q.start = 1'b0;
        next_q.abort_req = 1'b0;
        next_q.stat_pend = 1'b0;
        fsm_we = 1'b0;
        fsm_addr = q.ptr;
        fsm_wdata = '0;

        // Status word follows its result word by one cycle
        if (q.stat_pend) begin
            fsm_we = 1'b1;
            fsm_addr = q.ptr + LIST_AW'(1);
            fsm_wdata = q.stat_word;
        end

        // Register writes from software
        if (wr_en) begin
            if (acc_addr == MSH_ADDR_CTRL) begin
                next_q.exec = hwdata[MSH_CTRL_EXEC];
                next_q.abort = hwdata[MSH_CTRL_ABORT];
            end else if (acc_addr == MSH_ADDR_SEL) begin
                next_q.sel = hwdata;
            end else if (acc_addr == MSH_ADDR_PTR) begin
                next_q.ptr = hwdata[LIST_AW-1:0];
            end
        end

        case (q.st)
            MSH_ST_IDLE: begin
                if (abort_rise) begin
                    // Abort wins over a simultaneous execute
                    next_q.st = MSH_ST_ABORT;
                    next_q.busy = 1'b1;
                    next_q.abort_req = 1'b1;
                end else if (exec_rise) begin
                    if (sel_ok && ptr_ok) begin
                        next_q.st = MSH_ST_SEND;
                        next_q.busy = 1'b1;
                        next_q.start = 1'b1;
                        next_q.result = MSH_RES_BUSY;
                        fsm_we = !q.stat_pend;
                        fsm_wdata = {MSH_RES_BUSY, 8'h00};
                    end else begin
                        // Bad selectors end at once with error
                        next_q.error = 1'b1;
                        next_q.last_err = 1'b1;
                        next_q.last_ok = 1'b0;
                        next_q.result = {MSH_RES_ERR_HI, MSH_ERR_SELECT};
                    end
                end
            end
            MSH_ST_SEND: begin
                if (q.abort) begin
                    // Forced termination of the running send
                    next_q.st = MSH_ST_ABORT;
                    next_q.abort_req = 1'b1;
                end else if (xfer_rsp.fail) begin
                    next_q.st = MSH_ST_IDLE;
                    next_q.busy = 1'b0;
                    next_q.error = 1'b1;
                    next_q.last_err = 1'b1;
                    next_q.last_ok = 1'b0;
                    next_q.result = {MSH_RES_ERR_HI, xfer_rsp.code};
                    fsm_we = 1'b1;
                    fsm_addr = q.ptr;
                    fsm_wdata = {MSH_RES_ERR_HI, xfer_rsp.code,
                                 xfer_rsp.detail};
                    next_q.stat_pend = 1'b1;
                    next_q.stat_word = {8'h00, xfer_rsp.detail};
                end else if (xfer_rsp.done) begin
                    next_q.st = MSH_ST_IDLE;
                    next_q.busy = 1'b0;
                    next_q.complete = 1'b1;
                    next_q.last_ok = 1'b1;
                    next_q.last_err = 1'b0;
                    next_q.result = MSH_RES_DONE;
                    fsm_we = 1'b1;
                    fsm_addr = q.ptr;
                    fsm_wdata = {MSH_RES_DONE, 8'h00};
                    next_q.stat_pend = 1'b1;
                    next_q.stat_word = {8'h00, xfer_rsp.detail};
                end
            end
            MSH_ST_ABORT: begin
                // Engine confirms the abort by done or fail
                if (xfer_rsp.done || xfer_rsp.fail) begin
                    next_q.st = MSH_ST_IDLE;
                    next_q.busy = 1'b0;
                    next_q.complete = 1'b1;
                    next_q.last_ok = 1'b1;
                    next_q.last_err = 1'b0;
                    next_q.result = MSH_RES_DONE;
                end
            end
            default: begin
                next_q.st = MSH_ST_IDLE;
            end
        endcase

        // Read data captured during the read wait state
        if (rd_cap) begin
            if (acc_addr == MSH_ADDR_CTRL) begin
                next_q.rdata = {30'h0, q.abort, q.exec};
            end else if (acc_addr == MSH_ADDR_SEL) begin
                next_q.rdata = q.sel;
            end else if (acc_addr == MSH_ADDR_PTR) begin
                next_q.rdata = {{(32-LIST_AW){1'b0}}, q.ptr};
            end else if (acc_addr == MSH_ADDR_STAT) begin
                next_q.rdata = {16'h0, q.result, 5'h00,
                                q.last_err, q.last_ok, q.busy};
            end else if (list_hit) begin
                next_q.rdata = {16'h0, list_rdata};
            end else begin
                next_q.rdata = '0;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata = q.rdata;
    assign flags.busy = q.busy;
    assign flags.complete = q.complete;
    assign flags.error = q.error;
    assign xfer_req.start = q.start;
    assign xfer_req.abort = q.abort_req;
    // Raw modes expect nothing back
    assign xfer_req.expect_reply = (protocol == MSH_PROTO_REQRSP);
    assign xfer_req.byte_mode = (protocol == MSH_PROTO_RAW_BYTE);
    assign xfer_req.dev_type = dev_type;
    assign xfer_req.protocol = protocol;
    assign xfer_req.circuit = circuit;
    assign xfer_req.channel = channel;
    assign xfer_req.list_ptr = 8'(q.ptr);
endmodule

// file: tb/msh_top_properties.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Handshake checker, sees only the top ports
// ----------------------------------------------------------------
module msh_top_chk #(
    parameter int LIST_DEPTH = 64,
    parameter int LIST_AW = 6
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus side
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    // Engine side
    input wire msh_pkg::msh_xfer_req_s xfer_req,
    input wire msh_pkg::msh_xfer_rsp_s xfer_rsp,
    // Flags
    input wire msh_pkg::msh_flags_s flags
);
    // All checks run on the bus clock, off during reset
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_start_busy;
        xfer_req.start |-> flags.busy;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start without busy");
    property p_abort_busy;
        xfer_req.abort |-> flags.busy;
    endproperty
    a_abort_busy: assert property (p_abort_busy)
        else $error("abort without busy");
    property p_done_cmp;
        flags.busy && xfer_rsp.done |=> flags.complete && !flags.busy;
    endproperty
    a_done_cmp: assert property (p_done_cmp)
        else $error("done without complete");
    property p_cmp_one;
        flags.complete |=> !flags.complete;
    endproperty
    a_cmp_one: assert property (p_cmp_one)
        else $error("complete too long");
    property p_err_one;
        flags.error |=> !flags.error;
    endproperty
    a_err_one: assert property (p_err_one)
        else $error("error too long");
    property p_busy_hold;
        flags.busy && !xfer_rsp.done && !xfer_rsp.fail |=> flags.busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped early");
    property p_busy_end;
        $fell(flags.busy) |-> flags.complete || flags.error;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("busy ended without a flag");
    property p_excl;
        !(xfer_req.start && xfer_req.abort);
    endproperty
    a_excl: assert property (p_excl)
        else $error("start with abort");
    property p_rd_wait;
        hsel && hready && htrans[1] && !hwrite
            |=> !hreadyout [*2] ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait wrong");
    // Main scenarios reached
    c_cmp: cover property (flags.complete);
    c_err: cover property (flags.error);
    c_abort: cover property (xfer_req.abort);
endmodule
bind msh_top msh_top_chk #(.LIST_DEPTH(LIST_DEPTH), .LIST_AW(LIST_AW))
    u_msh_top_chk (.*);

// file: tb/msh_engine_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Transfer engine model, answers after a set delay
// ----------------------------------------------------------------
module msh_engine_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Test controls
    input wire logic fail_en,
    input wire logic [7:0] dly,
    // Engine side of the block
    input wire msh_pkg::msh_xfer_req_s xfer_req,
    output msh_pkg::msh_xfer_rsp_s xfer_rsp,
    output logic [5:0] eng_addr
);
    import msh_pkg::*;
    logic run, is_abort, pulse; // Transfer in flight and its kind
    logic [7:0] cnt, noise; // Delay count, filler for idle fields
    // Start or abort loads the delay; abort restarts it mid-send
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {run, is_abort, pulse, cnt, noise} <= '0;
        end else begin
            noise <= noise + 8'h1;
            pulse <= 1'b0;
            if (xfer_req.start || xfer_req.abort) begin
                run <= 1'b1;
                cnt <= dly;
                is_abort <= xfer_req.abort;
            end else if (run && cnt == 8'h0) begin
                run <= 1'b0;
                pulse <= 1'b1;
            end else if (run) begin
                cnt <= cnt - 8'h1;
            end
        end
    end
    // Reply and plain end of send look alike here; aborts never fail
    assign xfer_rsp.done = pulse & ~(fail_en & ~is_abort);
    assign xfer_rsp.fail = pulse & fail_en & ~is_abort;
    // Idle fields change each cycle so stale values are never trusted
    assign xfer_rsp.code = pulse ? 4'h3 : noise[3:0];
    assign xfer_rsp.detail = pulse ? 8'h5a : ~noise;
    // Reads the function code word inside the 17-word list
    assign eng_addr = xfer_req.list_ptr[5:0] + 6'h4;
endmodule

// file: tb/tb_message_send_handshake.sv
`timescale 1ns/10ps
module tb_message_send_handshake;
    import msh_pkg::*;
    // Selector row: sel word, list pointer, accepted, {reply, byte}
    typedef struct packed {
        logic [31:0] sel;
        logic [5:0] ptr;
        logic ok;
        logic [1:0] mode;
    } msh_row_s;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
    logic [1:0] htrans = 2'b00, f;
    logic hreadyout, hresp, fail_en = 1'b0;
    logic [7:0] dly = 8'h2;
    logic [5:0] eng_addr;
    logic [15:0] eng_rdata;
    msh_xfer_req_s xfer_req;
    msh_xfer_rsp_s xfer_rsp;
    msh_flags_s flags;
    msh_row_s row;
    int fails = 0, checks_done = 0, n_start = 0, n_abort = 0, n;
    // Sel word is {channel, circuit, protocol, device}
    msh_row_s rows [11] = '{
        '{32'h0a010106, 6'd0, 1'b1, 2'b10}, '{32'h04080210, 6'd47, 1'b1, 2'b00},
        '{32'h01030306, 6'd5, 1'b1, 2'b01}, '{32'h01010107, 6'd0, 1'b0, 2'b00},
        '{32'h01010406, 6'd0, 1'b0, 2'b00}, '{32'h01000106, 6'd0, 1'b0, 2'b00},
        '{32'h01090106, 6'd0, 1'b0, 2'b00}, '{32'h0b010106, 6'd0, 1'b0, 2'b00},
        '{32'h05010110, 6'd0, 1'b0, 2'b00}, '{32'h00010106, 6'd0, 1'b0, 2'b00},
        '{32'h01010106, 6'd48, 1'b0, 2'b00}};
    msh_top u_msh_top (.*, .hsize(3'h2), .hready(hreadyout));
    msh_engine_model u_msh_engine_model (.*);
    // 50 MHz clock
    always #10 hclk = ~hclk;
    // Count engine requests to catch spurious starts
    always @(posedge hclk) begin
        if (xfer_req.start === 1'b1) n_start++;
        if (xfer_req.abort === 1'b1) n_abort++;
    end
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    // One single word transfer; ready is judged at rising edges
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task ctrl(input logic [1:0] d);
        ahb(1'b1, MSH_ADDR_CTRL, {30'h0, d});
    endtask
    // Execute stays up until the one-cycle pulse
    task wait_flag;
        f = 2'b00;
        for (int i = 0; i < 300 && f == 2'b00; i++) begin
            @(posedge hclk);
            f = {flags.complete, flags.error};
        end
    endtask
    task give_verdict;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog, well past the run's length
    initial begin
        #200000;
        fails++;
        $display("unexpected timeout: expected end, seen hang");
        give_verdict;
    end
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk("reset state", 32'h1, {28'h0, flags, hreadyout} | hrdata);
        @(posedge hclk);
        // ----------------------------------------------------------
        // Selector table: valid codes with a fitting pointer complete, the rest refused
        // ----------------------------------------------------------
        for (int i = 0; i < 11; i++) begin
            row = rows[i];
            ahb(1'b1, MSH_ADDR_SEL, row.sel);
            ahb(1'b1, MSH_ADDR_PTR, {26'h0, row.ptr});
            if (row.ok) chk("mode", {30'h0, row.mode}, {30'h0,
                xfer_req.expect_reply, xfer_req.byte_mode});
            ctrl(2'h1);
            wait_flag;
            chk("flags", {30'h0, row.ok, !row.ok}, {30'h0, f});
            ctrl(2'h0);
            ahb(1'b0, MSH_ADDR_STAT, 32'h0);
            chk("status", row.ok ? 32'h1002 : 32'h8f04, q);
            if (row.ok) begin
                ahb(1'b0, MSH_ADDR_LIST + {4'h0, row.ptr, 2'b00}, 32'h0);
                chk("result word", 32'h1000, q);
            end
        end
        // Slow send: in-progress word, busy, then no restart on held bit
        dly <= 8'd20;
        ahb(1'b1, MSH_ADDR_PTR, 32'h0);
        ahb(1'b1, MSH_ADDR_LIST + 12'h010, 32'h1234);
        ctrl(2'h1);
        ahb(1'b0, MSH_ADDR_LIST, 32'h0);
        chk("in progress word", 32'h0, q);
        chk("engine read", 32'h1234, {16'h0, eng_rdata});
        ahb(1'b0, MSH_ADDR_STAT, 32'h0);
        chk("busy bit", 32'h1, q & 32'h1);
        wait_flag;
        chk("complete", 32'h2, {30'h0, f});
        n = n_start;
        repeat (10) @(posedge hclk);
        chk("no restart", n, n_start);
        // Abort raised in mid-send, execute still held
        ctrl(2'h0);
        ctrl(2'h1);
        n = n_abort;
        ctrl(2'h3);
        wait_flag;
        chk("abort end", 32'h2, {30'h0, f});
        chk("abort sent", 32'h1, {31'h0, n_abort > n});
        // Execute and abort together from idle: abort wins
        ctrl(2'h0);
        n = n_start;
        ctrl(2'h3);
        wait_flag;
        chk("both set", 32'h2, {30'h0, f});
        chk("no start", n, n_start);
        // Engine failure gives the error pulse and 8x result
        ctrl(2'h0);
        fail_en <= 1'b1;
        ctrl(2'h1);
        wait_flag;
        chk("error", 32'h1, {30'h0, f});
        fail_en <= 1'b0;
        ctrl(2'h0);
        ahb(1'b0, MSH_ADDR_LIST, 32'h0);
        chk("error word", 32'h835a, q);
        ahb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h0, q);
        // Reset in mid-send clears flags and controls
        ctrl(2'h1);
        repeat (3) @(posedge hclk);
        hresetn <= 1'b0;
        @(negedge hclk);
        chk("flags in reset", 32'h0, {29'h0, flags});
        @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, MSH_ADDR_CTRL, 32'h0);
        chk("ctrl after reset", 32'h0, q);
        give_verdict;
    end
endmodule
